//--- rtl/isem_pkg.sv
package isem_pkg;

  // ************************************************************
  // bus and widths
  // ************************************************************
  localparam int ISEM_DATA_W = 32;
  localparam int ISEM_ADDR_W = 8;
  localparam int ISEM_PIN_COUNT = 8;
  localparam int ISEM_DMA_COUNT = 4;
  localparam int ISEM_DB_COUNT = 8;
  localparam int ISEM_MBOX_COUNT = 8;
  localparam int ISEM_MAP_W = 3;
  localparam int ISEM_MAPS_PER_REG = 10;
  localparam int ISEM_MAP_REGS = 6;
  localparam int ISEM_PIN_FILTER = 3;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] ISEM_OFS_NORM_STATUS = 8'h00;
  localparam logic [7:0] ISEM_OFS_ERR_STATUS = 8'h04;
  localparam logic [7:0] ISEM_OFS_NORM_ENABLE = 8'h08;
  localparam logic [7:0] ISEM_OFS_ERR_ENABLE = 8'h0C;
  localparam logic [7:0] ISEM_OFS_DOORBELL = 8'h10;
  localparam logic [7:0] ISEM_OFS_DIRECTION = 8'h14;
  localparam logic [7:0] ISEM_OFS_MAP_BASE = 8'h20;
  localparam logic [7:0] ISEM_OFS_MBOX_BASE = 8'h40;

  // ************************************************************
  // normal-operation status layout
  // ************************************************************
  localparam int ISEM_NORM_HW_LSB = 0;
  localparam int ISEM_NORM_DMA_LSB = 8;
  localparam int ISEM_NORM_DB_LSB = 12;
  localparam int ISEM_NORM_MBOX_LSB = 20;
  localparam int ISEM_NORM_INPOST = 28;
  localparam int ISEM_NORM_OUTPOST = 29;
  localparam int ISEM_NORM_SRC = 30;
  localparam int ISEM_SUMMARY_BIT = 31;

  // ************************************************************
  // error status layout, groups of three: procbus, pci 1, pci 2
  // ************************************************************
  localparam int ISEM_ERR_PB_RETRY_LSB = 0;
  localparam int ISEM_ERR_PB_ERR_LSB = 3;
  localparam int ISEM_ERR_PB_APAR = 6;
  localparam int ISEM_ERR_PB_DPAR_LSB = 7;
  localparam int ISEM_ERR_P1_ERR_LSB = 10;
  localparam int ISEM_ERR_P1_APAR = 13;
  localparam int ISEM_ERR_P1_RETRY_LSB = 14;
  localparam int ISEM_ERR_P2_ERR_LSB = 17;
  localparam int ISEM_ERR_P2_APAR = 20;
  localparam int ISEM_ERR_P2_RETRY_LSB = 21;
  localparam int ISEM_ERR_SRC = 24;

  // ************************************************************
  // reset values and responses
  // ************************************************************
  localparam logic [31:0] ISEM_ZERO_RST = 32'h0000_0000;
  localparam logic [7:0] ISEM_DIR_RST = 8'h00;
  localparam logic [1:0] ISEM_RESP_OKAY = 2'h0;
  localparam logic [1:0] ISEM_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {ISEM_RD_IDLE, ISEM_RD_FETCH, ISEM_RD_RESP} isem_rd_state_type;

endpackage

//--- rtl/isem_mailbox_mem.sv
`timescale 1ns/1ps

module isem_mailbox_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk, // clock
  input wire logic i_ce, // clock enable
  input wire logic i_wr_en, // write strobe
  input wire logic [$clog2(DEPTH)-1:0] i_wr_addr, // write word
  input wire logic [WIDTH-1:0] i_wr_data, // write data
  input wire logic [WIDTH/8-1:0] i_wr_be, // byte enables
  input wire logic i_rd_en, // read strobe
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr, // read word
  output logic [WIDTH-1:0] o_rd_data // registered read data
);

  if (WIDTH % 8 != 0 || DEPTH < 2)
  begin : g_check
    $error("isem_mailbox_mem: unsupported width or depth");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // mailboxes carry no reset: software must write before it reads
  always_ff @(posedge i_core_clk)
  begin
    if (i_ce && i_wr_en)
    begin
      for (int b = 0; b < WIDTH / 8; b++)
      begin
        if (i_wr_be[b])
        begin
          mem[i_wr_addr][b*8 +: 8] <= i_wr_data[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_ce && i_rd_en)
    begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

//--- rtl/isem_top.sv
`timescale 1ns/1ps

// Contract
// RULE_01: an active source sets its status bit in the matching status register
// RULE_02: all status bits of both status registers read zero after reset
// RULE_03: status bits stay set until software writes one; zero leaves them
// RULE_04: normal status shows summary bit while any error status bit is set
// RULE_05: error status shows summary bit while any normal status bit is set
// RULE_06: read-only outbound post bit follows pending outbound frames; writes ignored
// RULE_07: write-one-clear inbound post bit set while inbound frames are pending
// RULE_08: each dma channel has its own write-one-clear status bit
// RULE_09: each of eight pins has a write-one-clear bit for input interrupts
// RULE_10: each doorbell has a write-one-clear bit set when the doorbell is written
// RULE_11: each mailbox has a write-one-clear bit set on every mailbox write
// RULE_12: procbus retry-limit bit set when procbus master exceeds allowed retries
// RULE_13: procbus error bit set on slave-asserted or master-received transfer error ack
// RULE_14: separate status bits for procbus address and data parity errors
// RULE_15: each pci interface has error bit and separate address parity bit
// RULE_16: each pci interface has retry-limit bit for its master
// RULE_17: grouped error names are distinct bits, one per counterpart port
// RULE_18: master-detected errors recorded by the transaction's source interface
// RULE_19: target-detected errors recorded by the transaction's destination port
// RULE_20: a set status bit drives its pin only when its enable is set
// RULE_21: every source has a programmable map selecting its output pin
// RULE_22: each pin has a direction bit, input only or output only
// RULE_23: eight 32-bit read/write mailbox registers for message passing
// RULE_24: map code 0 and 1 pick pci pins, 2 to 7 general pins
// RULE_25: all enable bits clear after reset
// RULE_26: pins active low, level; input needs three successive low samples
// RULE_27: every pin is an input after reset
// RULE_28: output pin driven low while any enabled mapped status bit is set
module isem_top
  import isem_pkg::*;
#(
  parameter int MAILBOX_COUNT = 8
) (
  input wire logic i_core_clk, // 200 MHz clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic [ISEM_ADDR_W-1:0] i_awaddr, // axi write address
  input wire logic i_awvalid, // axi write address valid
  output logic o_awready, // axi write address ready
  input wire logic [31:0] i_wdata, // axi write data
  input wire logic [3:0] i_wstrb, // axi write strobes
  input wire logic i_wvalid, // axi write data valid
  output logic o_wready, // axi write data ready
  output logic [1:0] o_bresp, // axi write response
  output logic o_bvalid, // axi write response valid
  input wire logic i_bready, // axi write response ready
  input wire logic [ISEM_ADDR_W-1:0] i_araddr, // axi read address
  input wire logic i_arvalid, // axi read address valid
  output logic o_arready, // axi read address ready
  output logic [31:0] o_rdata, // axi read data
  output logic [1:0] o_rresp, // axi read response
  output logic o_rvalid, // axi read valid
  input wire logic i_rready, // axi read ready
  input wire logic i_outbound_post_pending, // outbound list holds frames
  input wire logic i_inbound_post_pending, // inbound list holds frames
  input wire logic [ISEM_DMA_COUNT-1:0] i_dma_channel_event, // dma channel interrupt
  input wire logic [2:0] i_procbus_retry_limit, // by source: pb, pci1, pci2
  input wire logic [2:0] i_master_transfer_error_ack, // pb master got ack, by source
  input wire logic [2:0] i_slave_transfer_error_ack, // pb slave gave ack, by destination
  input wire logic i_procbus_addr_parity, // procbus address parity error
  input wire logic [2:0] i_procbus_data_parity, // procbus data parity, by port
  input wire logic [2:0] i_first_pci_error, // pci 1 error, by port
  input wire logic i_first_pci_addr_parity, // pci 1 address parity error
  input wire logic [2:0] i_first_pci_retry_limit, // pci 1 retry limit, by port
  input wire logic [2:0] i_second_pci_error, // pci 2 error, by port
  input wire logic i_second_pci_addr_parity, // pci 2 address parity error
  input wire logic [2:0] i_second_pci_retry_limit, // pci 2 retry limit, by port
  input wire logic [ISEM_PIN_COUNT-1:0] i_irq_pin_n, // pin levels, active low
  output logic [ISEM_PIN_COUNT-1:0] o_irq_pin_n, // pin drive value, always low
  output logic [ISEM_PIN_COUNT-1:0] o_irq_pin_oe // pin output enable
);

  if (MAILBOX_COUNT != ISEM_MBOX_COUNT)
  begin : g_check
    $error("isem_top: mailbox count must match the register layout");
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic is_map(input logic [7:0] a);
    return a >= ISEM_OFS_MAP_BASE && a < ISEM_OFS_MAP_BASE + 8'(ISEM_MAP_REGS * 4);
  endfunction

  function automatic logic is_mbox(input logic [7:0] a);
    return a >= ISEM_OFS_MBOX_BASE && a < ISEM_OFS_MBOX_BASE + 8'(ISEM_MBOX_COUNT * 4);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a <= ISEM_OFS_DIRECTION || is_map(a) || is_mbox(a));
  endfunction

  // ************************************************************
  // write channel
  // ************************************************************
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] wbits;

  assign o_awready = !aw_full && !o_bvalid;
  assign o_wready = !w_full && !o_bvalid;
  assign do_write = aw_full && w_full && !o_bvalid;
  assign wmask = strb_mask(w_strb);
  assign wbits = w_data & wmask;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (i_ce)
    begin
      if (i_awvalid && o_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= i_awaddr;
      end
      else if (do_write)
      begin
        aw_full <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_full <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      else if (do_write)
      begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= ISEM_RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (do_write)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= is_mapped(aw_addr) ? ISEM_RESP_OKAY : ISEM_RESP_DECERR;
      end
      else if (i_bready)
      begin
        o_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_at(input logic [7:0] ofs, input logic [7:0] a, input logic go);
    return go && a == ofs;
  endfunction

  // ************************************************************
  // control registers
  // ************************************************************
  logic [ISEM_NORM_SRC-1:0] norm_en;
  logic [ISEM_ERR_SRC-1:0] err_en;
  logic [ISEM_PIN_COUNT-1:0] pin_dir;
  logic [ISEM_MAPS_PER_REG*ISEM_MAP_W-1:0] map_reg [ISEM_MAP_REGS];
  logic [ISEM_MAP_REGS*ISEM_MAPS_PER_REG*ISEM_MAP_W-1:0] map_flat;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      // RULE_25: enables cleared
      norm_en <= '0;
      err_en <= '0;
      // RULE_27: pins start as inputs
      pin_dir <= ISEM_DIR_RST;
    end
    else if (i_ce)
    begin
      if (wr_at(ISEM_OFS_NORM_ENABLE, aw_addr, do_write))
      begin
        norm_en <= (norm_en & ~wmask[ISEM_NORM_SRC-1:0]) | wbits[ISEM_NORM_SRC-1:0];
      end
      if (wr_at(ISEM_OFS_ERR_ENABLE, aw_addr, do_write))
      begin
        err_en <= (err_en & ~wmask[ISEM_ERR_SRC-1:0]) | wbits[ISEM_ERR_SRC-1:0];
      end
      // RULE_22: direction per pin
      if (wr_at(ISEM_OFS_DIRECTION, aw_addr, do_write))
      begin
        pin_dir <= (pin_dir & ~wmask[7:0]) | wbits[7:0];
      end
    end
  end

  // RULE_21: one map field per source
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      for (int r = 0; r < ISEM_MAP_REGS; r++)
      begin
        map_reg[r] <= '0;
      end
    end
    else if (i_ce && do_write && is_map(aw_addr))
    begin
      map_reg[aw_addr[4:2]] <= (map_reg[aw_addr[4:2]] & ~wmask[29:0]) | wbits[29:0];
    end
  end

  always_comb
  begin
    for (int r = 0; r < ISEM_MAP_REGS; r++)
    begin
      map_flat[r*30 +: 30] = map_reg[r];
    end
  end

  // ************************************************************
  // mailboxes
  // ************************************************************
  logic mbox_wr;
  logic [ISEM_MBOX_COUNT-1:0] mbox_hit;
  logic [31:0] mbox_rd_data;
  logic ar_take;

  assign mbox_wr = do_write && is_mbox(aw_addr);
  assign ar_take = i_arvalid && o_arready;

  always_comb
  begin
    mbox_hit = '0;
    mbox_hit[aw_addr[4:2]] = mbox_wr;
  end

  // RULE_23: eight word mailboxes
  isem_mailbox_mem #(
    .WIDTH(32),
    .DEPTH(ISEM_MBOX_COUNT)
  ) u_mailbox (
    .i_core_clk(i_core_clk),
    .i_ce(i_ce),
    .i_wr_en(mbox_wr),
    .i_wr_addr(aw_addr[4:2]),
    .i_wr_data(w_data),
    .i_wr_be(w_strb),
    .i_rd_en(ar_take),
    .i_rd_addr(i_araddr[4:2]),
    .o_rd_data(mbox_rd_data)
  );

  // ************************************************************
  // pin input filter
  // ************************************************************
  logic [ISEM_PIN_FILTER-1:0] pin_hist [ISEM_PIN_COUNT];
  logic [ISEM_PIN_COUNT-1:0] pin_seen;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      for (int p = 0; p < ISEM_PIN_COUNT; p++)
      begin
        pin_hist[p] <= '1;
      end
    end
    else if (i_ce)
    begin
      for (int p = 0; p < ISEM_PIN_COUNT; p++)
      begin
        pin_hist[p] <= {pin_hist[p][ISEM_PIN_FILTER-2:0], i_irq_pin_n[p]};
      end
    end
  end

  // RULE_26: three successive low samples
  always_comb
  begin
    for (int p = 0; p < ISEM_PIN_COUNT; p++)
    begin
      pin_seen[p] = !pin_dir[p] && pin_hist[p] == '0;
    end
  end

  // ************************************************************
  // status registers
  // ************************************************************
  logic [ISEM_NORM_SRC-1:0] norm_stat;
  logic [ISEM_ERR_SRC-1:0] err_stat;
  logic [ISEM_NORM_SRC-1:0] norm_set;
  logic [ISEM_ERR_SRC-1:0] err_set;
  logic [ISEM_NORM_SRC-1:0] norm_clr;
  logic [ISEM_ERR_SRC-1:0] err_clr;
  logic [ISEM_DB_COUNT-1:0] db_ring;

  assign db_ring = wr_at(ISEM_OFS_DOORBELL, aw_addr, do_write) ? wbits[7:0] : '0;

  always_comb
  begin
    norm_set = '0;
    // RULE_09: pin input events
    norm_set[ISEM_NORM_HW_LSB +: ISEM_PIN_COUNT] = pin_seen;
    // RULE_08: dma channel events
    norm_set[ISEM_NORM_DMA_LSB +: ISEM_DMA_COUNT] = i_dma_channel_event;
    // RULE_10: doorbell written
    norm_set[ISEM_NORM_DB_LSB +: ISEM_DB_COUNT] = db_ring;
    // RULE_11: mailbox written
    norm_set[ISEM_NORM_MBOX_LSB +: ISEM_MBOX_COUNT] = mbox_hit;
    // RULE_07: inbound post pending
    norm_set[ISEM_NORM_INPOST] = i_inbound_post_pending;
  end

  // RULE_17: one bit per counterpart port in every group
  always_comb
  begin
    err_set = '0;
    // RULE_12: procbus retry limit
    err_set[ISEM_ERR_PB_RETRY_LSB +: 3] = i_procbus_retry_limit;
    // RULE_13: transfer error ack either role
    // RULE_18: master side indexed by source
    // RULE_19: slave side indexed by destination
    err_set[ISEM_ERR_PB_ERR_LSB +: 3] = i_master_transfer_error_ack | i_slave_transfer_error_ack;
    // RULE_14: address and data parity apart
    err_set[ISEM_ERR_PB_APAR] = i_procbus_addr_parity;
    err_set[ISEM_ERR_PB_DPAR_LSB +: 3] = i_procbus_data_parity;
    // RULE_15: pci error and address parity
    err_set[ISEM_ERR_P1_ERR_LSB +: 3] = i_first_pci_error;
    err_set[ISEM_ERR_P1_APAR] = i_first_pci_addr_parity;
    err_set[ISEM_ERR_P2_ERR_LSB +: 3] = i_second_pci_error;
    err_set[ISEM_ERR_P2_APAR] = i_second_pci_addr_parity;
    // RULE_16: pci retry limit
    err_set[ISEM_ERR_P1_RETRY_LSB +: 3] = i_first_pci_retry_limit;
    err_set[ISEM_ERR_P2_RETRY_LSB +: 3] = i_second_pci_retry_limit;
  end

  // the outbound bit is never cleared by software
  assign norm_clr = wr_at(ISEM_OFS_NORM_STATUS, aw_addr, do_write)
    ? {1'b0, wbits[ISEM_NORM_SRC-2:0]} : '0;
  assign err_clr = wr_at(ISEM_OFS_ERR_STATUS, aw_addr, do_write) ? wbits[ISEM_ERR_SRC-1:0] : '0;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      // RULE_02: status clear after reset
      norm_stat <= ISEM_ZERO_RST[ISEM_NORM_SRC-1:0];
      err_stat <= ISEM_ZERO_RST[ISEM_ERR_SRC-1:0];
    end
    else if (i_ce)
    begin
      // RULE_01: set on active source
      // RULE_03: sticky, write one clears, set wins
      norm_stat[ISEM_NORM_SRC-2:0] <= (norm_stat[ISEM_NORM_SRC-2:0] & ~norm_clr[ISEM_NORM_SRC-2:0])
        | norm_set[ISEM_NORM_SRC-2:0];
      // RULE_06: read-only level of the outbound list
      norm_stat[ISEM_NORM_OUTPOST] <= i_outbound_post_pending;
      err_stat <= (err_stat & ~err_clr) | err_set;
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  logic [ISEM_PIN_COUNT-1:0] next_drive;

  always_comb
  begin
    next_drive = '0;
    for (int s = 0; s < ISEM_NORM_SRC; s++)
    begin
      // RULE_20: only enabled sources drive
      // RULE_24: map code is the pin index
      if (norm_stat[s] && norm_en[s])
      begin
        next_drive[map_flat[s*ISEM_MAP_W +: ISEM_MAP_W]] = 1'b1;
      end
    end
    for (int e = 0; e < ISEM_ERR_SRC; e++)
    begin
      if (err_stat[e] && err_en[e])
      begin
        next_drive[map_flat[(ISEM_NORM_SRC+e)*ISEM_MAP_W +: ISEM_MAP_W]] = 1'b1;
      end
    end
  end

  // open drain: the value is always low, only the enable moves
  assign o_irq_pin_n = '0;

  // RULE_28: drive low while any mapped enabled bit is set
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_irq_pin_oe <= '0;
    end
    else if (i_ce)
    begin
      o_irq_pin_oe <= pin_dir & next_drive;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  isem_rd_state_type rd_state;
  logic [7:0] ar_addr;
  logic [31:0] next_rdata;

  assign o_arready = rd_state == ISEM_RD_IDLE;
  assign o_rvalid = rd_state == ISEM_RD_RESP;

  always_comb
  begin
    next_rdata = '0;
    if (is_map(ar_addr))
    begin
      next_rdata[29:0] = map_reg[ar_addr[4:2]];
    end
    else if (is_mbox(ar_addr))
    begin
      next_rdata = mbox_rd_data;
    end
    else
    begin
      case (ar_addr)
        ISEM_OFS_NORM_STATUS:
        begin
          next_rdata[ISEM_NORM_SRC-1:0] = norm_stat;
          // RULE_04: any error bit set
          next_rdata[ISEM_SUMMARY_BIT] = |err_stat;
        end
        ISEM_OFS_ERR_STATUS:
        begin
          next_rdata[ISEM_ERR_SRC-1:0] = err_stat;
          // RULE_05: any normal bit set
          next_rdata[ISEM_SUMMARY_BIT] = |norm_stat;
        end
        ISEM_OFS_NORM_ENABLE: next_rdata[ISEM_NORM_SRC-1:0] = norm_en;
        ISEM_OFS_ERR_ENABLE: next_rdata[ISEM_ERR_SRC-1:0] = err_en;
        ISEM_OFS_DIRECTION: next_rdata[7:0] = pin_dir;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rd_state <= ISEM_RD_IDLE;
      ar_addr <= '0;
      o_rdata <= '0;
      o_rresp <= ISEM_RESP_OKAY;
    end
    else if (i_ce)
    begin
      case (rd_state)
        ISEM_RD_IDLE:
        begin
          if (i_arvalid)
          begin
            ar_addr <= i_araddr;
            rd_state <= ISEM_RD_FETCH;
          end
        end
        ISEM_RD_FETCH:
        begin
          o_rdata <= next_rdata;
          o_rresp <= is_mapped(ar_addr) ? ISEM_RESP_OKAY : ISEM_RESP_DECERR;
          rd_state <= ISEM_RD_RESP;
        end
        ISEM_RD_RESP:
        begin
          if (i_rready)
          begin
            rd_state <= ISEM_RD_IDLE;
          end
        end
        default: rd_state <= ISEM_RD_IDLE;
      endcase
    end
  end

endmodule

//--- verification/isem_chk.sv
`timescale 1ns/1ps
// ****
// bus and pin checks
// ****
module isem_chk
  import isem_pkg::*;
(
  input wire logic i_core_clk, // clock
  input wire logic i_rst, // reset
  input wire logic i_awvalid, // aw valid
  input wire logic o_awready, // aw ready
  input wire logic i_wvalid, // w valid
  input wire logic o_wready, // w ready
  input wire logic o_bvalid, // b valid
  input wire logic [1:0] o_bresp, // b resp
  input wire logic i_bready, // b ready
  input wire logic i_arvalid, // ar valid
  input wire logic o_arready, // ar ready
  input wire logic o_rvalid, // r valid
  input wire logic [31:0] o_rdata, // r data
  input wire logic i_rready, // r ready
  input wire logic [ISEM_PIN_COUNT-1:0] o_irq_pin_n, // pin value
  input wire logic [ISEM_PIN_COUNT-1:0] o_irq_pin_oe // pin enable
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  a_rst_quiet: assert property ($fell(i_rst) |-> o_irq_pin_oe == '0 && !o_bvalid && !o_rvalid)
    else $error("pin or response active after reset");
  a_open_drain: assert property (o_irq_pin_n == '0)
    else $error("pin drive value not low");
  a_rd_answer: assert property (i_arvalid && o_arready |=> ##[1:2] o_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> ##[1:2] o_bvalid)
    else $error("write answer late");
  a_b_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_r_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while answer pending");
  a_aw_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answer pending");
endmodule
bind isem_top isem_chk u_chk (.*);

//--- verification/isem_pin_host.sv
`timescale 1ns/1ps
// ****
// wired open-drain pins with pull-up
// ****
module isem_pin_host (
  input wire logic [7:0] i_oe, // device pulls low
  input wire logic [7:0] i_ext_low, // host pulls low
  output logic [7:0] o_level_n // wire level
);
  assign o_level_n = ~(i_oe | i_ext_low);
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
// ****
// register and pin bench
// ****
module tb_top
  import isem_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, obp = 1'h0, ibp = 1'h0;
  logic [7:0] awa = '0, ara = '0, ext = '0;
  logic [31:0] wd = '0;
  logic [3:0] dma = '0;
  logic [26:0] ev = '0;
  logic [26:0] evx;
  logic [31:0] seed = 32'hbba2_1550;
  logic [31:0] mb [8];
  logic [33:0] exq [$];
  logic awr, wrr, bv, arr, rv;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [7:0] pn, oe, lvl;
  int err_total = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  isem_top dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'h1), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrr), .o_bresp(br), .o_bvalid(bv), .i_bready(bry),
    .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv),
    .i_rready(rry), .i_outbound_post_pending(obp), .i_inbound_post_pending(ibp), .i_dma_channel_event(dma),
    .i_procbus_retry_limit(ev[2:0]), .i_master_transfer_error_ack(ev[5:3]), .i_slave_transfer_error_ack(ev[8:6]),
    .i_procbus_addr_parity(ev[9]), .i_procbus_data_parity(ev[12:10]), .i_first_pci_error(ev[15:13]),
    .i_first_pci_addr_parity(ev[16]), .i_first_pci_retry_limit(ev[19:17]), .i_second_pci_error(ev[22:20]),
    .i_second_pci_addr_parity(ev[23]), .i_second_pci_retry_limit(ev[26:24]), .i_irq_pin_n(lvl),
    .o_irq_pin_n(pn), .o_irq_pin_oe(oe));
  isem_pin_host host (.i_oe(oe), .i_ext_low(ext), .o_level_n(lvl));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ta = 1'h0;
    logic tw = 1'h0;
    exq.push_back({32'h0000_0000, r});
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do
    begin
      @(negedge clk);
      ta = ta || (awv && awr);
      tw = tw || (wv && wrr);
      @(posedge clk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end
    while (!ta || !tw);
    do @(negedge clk); while (!bv);
    // late ready keeps the response standing for a cycle
    @(posedge clk);
    bry <= 1'h1;
    @(posedge clk);
    bry <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    exq.push_back({e, r});
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'h0;
    do @(negedge clk); while (!rv);
    @(posedge clk);
    rry <= 1'h1;
    @(posedge clk);
    rry <= 1'h0;
  endtask
  // one dma pulse, then pins compared once the drive has settled
  task automatic kick(input logic [7:0] e);
    @(posedge clk);
    dma <= 4'h1;
    @(posedge clk);
    dma <= 4'h0;
    repeat (3) @(negedge clk);
    chk({26'h0, oe}, {26'h0, e});
    chk({26'h0, lvl}, {26'h0, ~e});
  endtask
  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (bv && bry) chk({32'h0000_0000, br}, exq.pop_front());
    if (rv && rry) chk({rdat, rr}, exq.pop_front());
  end
  initial
  begin
    #50000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), '0);
    rd(8'h18, '0, ISEM_RESP_DECERR);
    wr(8'h1c, 32'h0000_0001, ISEM_RESP_DECERR);
    for (int i = 0; i < 8; i++)
    begin
      mb[i] = rnd();
      wr(8'(64 + 4 * i), mb[i]);
    end
    for (int i = 0; i < 8; i++) rd(8'(64 + 4 * i), mb[i]);
    rd(8'h04, 32'h8000_0000);
    wr(8'h00, '0);
    rd(8'h00, 32'h0ff0_0000);
    wr(8'h00, 32'h0ff0_0000);
    evx = 27'(rnd());
    dma <= 4'ha;
    ibp <= 1'h1;
    ev <= evx;
    @(posedge clk);
    dma <= 4'h0;
    ibp <= 1'h0;
    ev <= '0;
    // either doorbell bit layout rings bells 0 and 7
    wr(8'h10, 32'h0008_1081);
    rd(8'h00, {|evx, 3'h1, 8'h00, 8'h81, 4'ha, 8'h00});
    rd(8'h04, {1'h1, 7'h0, evx[26:13], evx[12:9], evx[5:3] | evx[8:6], evx[2:0]});
    wr(8'h04, 32'h00ff_ffff);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h04, '0);
    obp <= 1'h1;
    wr(8'h00, 32'h2000_0000);
    rd(8'h00, 32'h2000_0000);
    obp <= 1'h0;
    ext <= 8'h04;
    repeat (2) @(posedge clk);
    ext <= 8'h00;
    rd(8'h00, '0);
    ext <= 8'h04;
    repeat (4) @(posedge clk);
    ext <= 8'h00;
    rd(8'h00, 32'h0000_0004);
    wr(8'h00, 32'h0000_0004);
    wr(8'h14, 32'h0000_00ff);
    kick(8'h00);
    ext <= 8'h04;
    repeat (4) @(posedge clk);
    ext <= 8'h00;
    rd(8'h00, 32'h0000_0100);
    wr(8'h08, 32'h0000_0100);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h00, 32'h0000_0100);
      wr(8'h20, 32'(c) << 24);
      kick(8'h01 << c);
    end
    wr(8'h00, 32'h0000_0100);
    kick(8'h80);
    wr(8'h00, 32'h0000_0100);
    repeat (3) @(negedge clk);
    chk({26'h0, oe}, '0);
    wrap_up();
  end
endmodule
